// File: logic/plxc_exec.v
// What this block does
// - Add-pointer adds unsigned 6-bit k to pointer chosen by f, writes back.
// - High byte 1110 1000 with f equal 11 decodes add-pointer-2-and-return.
// - Add-pointer-2-and-return adds k to pointer 2, stores in pointer 2.
// - Then it returns: program counter loads the return stack top.
// - Add-pointer-2-and-return takes two cycles; second cycle is a no-operation.
// - Call-via-working-reg pushes program counter plus 2 onto return stack.
// - Call-via-working-reg puts working reg into pc low byte; old byte lost.
// - Call copies high latch to pc high byte, upper latch to upper bits.
// - Call's second cycle is a no-operation while the target is fetched.
// - Call offers no shadow save of working, status or bank select regs.
// - Call decodes from opcode 0000 0000 0001 0100, completes in 2 cycles.
// - These instructions are recognised only when extended set is enabled.
`timescale 1ns/100ps
`default_nettype none
`include "plxc_defines.vh"

module plxc_exec (
	// Clock and reset
	input wire clk_sys,
	input wire rst,
	// Configuration
	input wire extended_set_enable,
	// Instruction from the fetch stage, one per instruction cycle
	input wire instr_valid,
	input wire [15:0] instr_word,
	// Core state read by the block
	input wire [`PLXC_PC_W-1:0] pc_current,
	input wire [`PLXC_PC_W-1:0] return_stack_top,
	input wire [7:0] working_reg,
	input wire [7:0] pc_high_latch,
	input wire [4:0] pc_upper_latch,
	// Pointer register writes
	output reg ptr_we,
	output reg [1:0] ptr_sel,
	output reg [`PLXC_PTR_W-1:0] ptr_wdata,
	// Program counter load and return stack push
	output reg pc_load,
	output reg [`PLXC_PC_W-1:0] pc_next,
	output reg stack_push,
	output reg [`PLXC_PC_W-1:0] stack_push_data,
	// Second-cycle no-operation and status
	output reg nop_cycle,
	output reg instr_taken,
	output wire status_write_en,
	output wire shadow_save_en,
	// Pointer register contents
	output wire [`PLXC_PTR_W-1:0] pointer_reg_0,
	output wire [`PLXC_PTR_W-1:0] pointer_reg_1,
	output wire [`PLXC_PTR_W-1:0] pointer_reg_2
);

////////////////////////////////////////////////////////////////////////////////

localparam ST_EXEC = 1'b0;
localparam ST_NOP = 1'b1;

reg state;
reg next_state;

// Next values of the registered outputs
reg next_ptr_we;
reg [1:0] next_ptr_sel;
reg [`PLXC_PTR_W-1:0] next_ptr_wdata;
reg next_pc_load;
reg [`PLXC_PC_W-1:0] next_pc_next;
reg next_stack_push;
reg [`PLXC_PC_W-1:0] next_stack_push_data;
reg next_nop_cycle;
reg next_instr_taken;

// Pointer bank, pointer n in field n
wire [3*`PLXC_PTR_W-1:0] ptr_bank;
reg [2:0] ptr_hit;
reg [1:0] sel_idx;
reg [`PLXC_PTR_W-1:0] sel_value;
wire [`PLXC_PTR_W-1:0] ptr_sum;

// Decode
wire [7:0] op_hi;
wire [1:0] op_f;
wire [5:0] op_k;
wire [`PLXC_PTR_W-1:0] k_ext;
wire take;
wire hit_hi;
wire dec_add;
wire dec_ret;
wire dec_call;
wire ptr_write;

////////////////////////////////////////////////////////////////////////////////

assign op_hi = instr_word[`PLXC_HI_MSB:`PLXC_HI_LSB];
assign op_f = instr_word[`PLXC_F_MSB:`PLXC_F_LSB];
assign op_k = instr_word[`PLXC_K_MSB:`PLXC_K_LSB];
assign k_ext = {{(`PLXC_PTR_W-6){1'b0}}, op_k};

// An instruction arriving in the flush cycle is the discarded prefetch
assign take = instr_valid && extended_set_enable && (state == ST_EXEC);
assign hit_hi = take && (op_hi == `PLXC_OP_ADD_PTR_HI);
assign dec_add = hit_hi && (op_f != `PLXC_F_PTR2_RET);
assign dec_ret = hit_hi && (op_f == `PLXC_F_PTR2_RET);
assign dec_call = take && (instr_word == `PLXC_OP_CALL_WORK);
assign ptr_write = dec_add || dec_ret;

////////////////////////////////////////////////////////////////////////////////

// The return form always works on pointer 2, whatever f holds
always @* begin
	sel_idx = op_f;
	if (dec_ret) begin
		sel_idx = 2'h2;
	end
end

always @* begin
	case (sel_idx)
	2'h0: begin
		sel_value = ptr_bank[`PLXC_PTR_W-1:0];
	end
	2'h1: begin
		sel_value = ptr_bank[2*`PLXC_PTR_W-1:`PLXC_PTR_W];
	end
	default: begin
		sel_value = ptr_bank[3*`PLXC_PTR_W-1:2*`PLXC_PTR_W];
	end
	endcase
end

// One-hot write strobe, so each pointer has a single writer
always @* begin
	ptr_hit = 3'h0;
	if (ptr_write) begin
		case (sel_idx)
		2'h0: begin
			ptr_hit = 3'h1;
		end
		2'h1: begin
			ptr_hit = 3'h2;
		end
		default: begin
			ptr_hit = 3'h4;
		end
		endcase
	end
end

// Carry out of the top bit is dropped: pointers wrap and no flag is made
assign ptr_sum = sel_value + k_ext;

////////////////////////////////////////////////////////////////////////////////

genvar gi;
generate
	for (gi = 0; gi < 3; gi = gi + 1) begin : g_ptr
		reg [`PLXC_PTR_W-1:0] ptr_q;
		always @(posedge clk_sys) begin
			if (rst) begin
				ptr_q <= `PLXC_PTR_RST;
			end else if (ptr_hit[gi]) begin
				ptr_q <= ptr_sum;
			end
		end
		assign ptr_bank[gi*`PLXC_PTR_W +: `PLXC_PTR_W] = ptr_q;
	end
endgenerate

assign pointer_reg_0 = ptr_bank[`PLXC_PTR_W-1:0];
assign pointer_reg_1 = ptr_bank[2*`PLXC_PTR_W-1:`PLXC_PTR_W];
assign pointer_reg_2 = ptr_bank[3*`PLXC_PTR_W-1:2*`PLXC_PTR_W];

// Tied off: none of these instructions touch status or shadow copies
assign status_write_en = 1'b0;
assign shadow_save_en = 1'b0;

////////////////////////////////////////////////////////////////////////////////

always @* begin
	next_state = state;
	next_ptr_we = ptr_write;
	next_ptr_sel = ptr_sel;
	next_ptr_wdata = ptr_wdata;
	next_pc_load = 1'b0;
	next_pc_next = pc_next;
	next_stack_push = 1'b0;
	next_stack_push_data = stack_push_data;
	next_nop_cycle = 1'b0;
	next_instr_taken = ptr_write || dec_call;
	if (ptr_write) begin
		next_ptr_sel = sel_idx;
		next_ptr_wdata = ptr_sum;
	end
	case (state)
	ST_EXEC: begin
		if (dec_ret) begin
			// Pointer update and return issue together; one flush follows
			next_pc_load = 1'b1;
			next_pc_next = return_stack_top;
			next_state = ST_NOP;
		end else if (dec_call) begin
			next_stack_push = 1'b1;
			next_stack_push_data = pc_current + `PLXC_RET_OFS;
			next_pc_load = 1'b1;
			// Old low byte is simply overwritten, never saved
			next_pc_next = {pc_upper_latch, pc_high_latch, working_reg};
			next_state = ST_NOP;
		end
	end
	ST_NOP: begin
		// The prefetched word is thrown away while the target is fetched
		next_nop_cycle = 1'b1;
		next_state = ST_EXEC;
	end
	default: begin
		next_state = ST_EXEC;
	end
	endcase
end

////////////////////////////////////////////////////////////////////////////////

always @(posedge clk_sys) begin
	if (rst) begin
		state <= ST_EXEC;
		ptr_we <= 1'b0;
		ptr_sel <= 2'h0;
		ptr_wdata <= `PLXC_PTR_RST;
		pc_load <= 1'b0;
		pc_next <= `PLXC_PC_RST;
		stack_push <= 1'b0;
		stack_push_data <= `PLXC_PC_RST;
		nop_cycle <= 1'b0;
		instr_taken <= 1'b0;
	end else begin
		state <= next_state;
		ptr_we <= next_ptr_we;
		ptr_sel <= next_ptr_sel;
		ptr_wdata <= next_ptr_wdata;
		pc_load <= next_pc_load;
		pc_next <= next_pc_next;
		stack_push <= next_stack_push;
		stack_push_data <= next_stack_push_data;
		nop_cycle <= next_nop_cycle;
		instr_taken <= next_instr_taken;
	end
end

endmodule
`default_nettype wire

// File: pkg/plxc_defines.vh
`ifndef PLXC_DEFINES_VH
`define PLXC_DEFINES_VH

// Opcode patterns
`define PLXC_OP_ADD_PTR_HI 8'he8
`define PLXC_OP_CALL_WORK 16'h0014
`define PLXC_F_PTR2_RET 2'h3

// Field positions in the instruction word
`define PLXC_HI_MSB 15
`define PLXC_HI_LSB 8
`define PLXC_F_MSB 7
`define PLXC_F_LSB 6
`define PLXC_K_MSB 5
`define PLXC_K_LSB 0

// Widths
`define PLXC_PTR_W 12
`define PLXC_PC_W 21
`define PLXC_RET_OFS 21'h000002

// Reset values
`define PLXC_PTR_RST 12'h000
`define PLXC_PC_RST 21'h000000

`endif

// File: test/plxc_checker.sv
`timescale 1ns/100ps
`default_nettype none
module plxc_chk (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Decoder inputs
	input wire logic extended_set_enable,
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	// Core state
	input wire logic [20:0] pc_current,
	input wire logic [20:0] return_stack_top,
	input wire logic [7:0] working_reg,
	input wire logic [7:0] pc_high_latch,
	input wire logic [4:0] pc_upper_latch,
	// Block outputs
	input wire logic ptr_we,
	input wire logic [1:0] ptr_sel,
	input wire logic pc_load,
	input wire logic [20:0] pc_next,
	input wire logic stack_push,
	input wire logic [20:0] stack_push_data,
	input wire logic nop_cycle,
	input wire logic instr_taken,
	input wire logic [11:0] pointer_reg_2
);
	// In the flush cycle pc_load is still high at the sampling edge
	wire go = instr_valid && extended_set_enable && !pc_load;
	wire ret = go && instr_word[15:6] == 10'h3a3;
	wire add = go && instr_word[15:8] == 8'he8 && !ret;
	wire call = go && instr_word == 16'h0014;
	wire any_hit = add || ret || call;
	wire [1:0] f_fld = instr_word[7:6];
	wire [11:0] k_fld = {6'h0, instr_word[5:0]};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_ptr_sel: assert property (add |=> ptr_we && ptr_sel == $past(f_fld))
		else $error("sel");
	a_ptr2_sum: assert property (ret |=> pointer_reg_2 == $past(pointer_reg_2) + $past(k_fld))
		else $error("ptr2 sum");
	a_ret_target: assert property (ret |=> pc_next == $past(return_stack_top))
		else $error("ret target");
	a_call_target: assert property (call |=>
		pc_next == {$past(pc_upper_latch), $past(pc_high_latch), $past(working_reg)})
		else $error("call target");
	a_add_one: assert property (add |=> !pc_load && !stack_push) else $error("add");
	a_ret_sel: assert property (ret |=> ptr_sel == 2'h2 && pc_load) else $error("ret");
	a_call_load: assert property (call |=> pc_load && stack_push) else $error("call");
	a_push_addr: assert property (call |=> stack_push_data == $past(pc_current) + 21'h2)
		else $error("push");
	a_nop_next: assert property (pc_load |=> nop_cycle) else $error("nop");
	a_nop_quiet: assert property (nop_cycle |-> !ptr_we && !pc_load && !instr_taken)
		else $error("flush");
	a_taken_cause: assert property (instr_taken |-> $past(any_hit))
		else $error("taken");
	cover property (ret);
	cover property (call);
	cover property (add ##1 add);
endmodule
bind plxc_exec plxc_chk plxc_chk_i (
	.clk_sys(clk_sys),
	.rst(rst),
	.extended_set_enable(extended_set_enable),
	.instr_valid(instr_valid),
	.instr_word(instr_word),
	.pc_current(pc_current),
	.return_stack_top(return_stack_top),
	.working_reg(working_reg),
	.pc_high_latch(pc_high_latch),
	.pc_upper_latch(pc_upper_latch),
	.ptr_we(ptr_we),
	.ptr_sel(ptr_sel),
	.pc_load(pc_load),
	.pc_next(pc_next),
	.stack_push(stack_push),
	.stack_push_data(stack_push_data),
	.nop_cycle(nop_cycle),
	.instr_taken(instr_taken),
	.pointer_reg_2(pointer_reg_2)
);
`default_nettype wire

// File: test/tb_plxc_exec.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
	$display("BAD %0t %h %h", $time, a, b); end end
module tb_plxc_exec;
	logic clk_sys = 0, rst = 1, extended_set_enable = 0, instr_valid = 0;
	logic [15:0] instr_word = 0;
	logic [20:0] pc_current = 0, return_stack_top = 0;
	logic [7:0] working_reg = 0, pc_high_latch = 0;
	logic [4:0] pc_upper_latch = 0;
	wire ptr_we, pc_load, stack_push, nop_cycle, instr_taken, status_write_en, shadow_save_en;
	wire [1:0] ptr_sel;
	wire [11:0] ptr_wdata, pointer_reg_0, pointer_reg_1, pointer_reg_2;
	wire [20:0] pc_next, stack_push_data;
	logic [11:0] m [3] = '{0, 0, 0};
	logic [31:0] r, q;
	logic [2:0] k;
	int bad_count = 0, cmp_count = 0, seed = 32'h8b10f0f7, i, s;
	plxc_exec plxc_exec_i (
		.clk_sys(clk_sys),
		.rst(rst),
		.extended_set_enable(extended_set_enable),
		.instr_valid(instr_valid),
		.instr_word(instr_word),
		.pc_current(pc_current),
		.return_stack_top(return_stack_top),
		.working_reg(working_reg),
		.pc_high_latch(pc_high_latch),
		.pc_upper_latch(pc_upper_latch),
		.ptr_we(ptr_we),
		.ptr_sel(ptr_sel),
		.ptr_wdata(ptr_wdata),
		.pc_load(pc_load),
		.pc_next(pc_next),
		.stack_push(stack_push),
		.stack_push_data(stack_push_data),
		.nop_cycle(nop_cycle),
		.instr_taken(instr_taken),
		.status_write_en(status_write_en),
		.shadow_save_en(shadow_save_en),
		.pointer_reg_0(pointer_reg_0),
		.pointer_reg_1(pointer_reg_1),
		.pointer_reg_2(pointer_reg_2)
	);
	function automatic [11:0] sum(input [11:0] p, input [5:0] x);
		sum = p + x;
	endfunction
	task final_report;
		$display("bad %0d of %0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial forever #5 clk_sys = ~clk_sys;
	initial begin
		#100000;
		bad_count++;
		final_report;
	end
	initial begin
		repeat (20) @(negedge clk_sys);
		rst = 0;
		// Kinds: 0-2 add, 3 return, 4 call, 5 disabled, 6 other opcode, 7 not valid
		for (i = 0; i < 1500; i++) begin
			if (i == 750) begin
				// Mid-run reset with an add on the bus: it must not be taken
				rst = 1;
				extended_set_enable = 1;
				instr_valid = 1;
				instr_word = 16'he801;
				repeat (3) @(negedge clk_sys);
				`CHK({ptr_we, pc_load, stack_push, nop_cycle, instr_taken, ptr_sel}, 7'h0)
				`CHK({ptr_wdata, pc_next, stack_push_data}, 54'h0)
				`CHK({pointer_reg_2, pointer_reg_1, pointer_reg_0}, 36'h0)
				m = '{0, 0, 0};
				rst = 0;
			end
			r = $random(seed);
			q = $random(seed);
			k = i < 8 ? i[2:0] : r[2:0];
			if (i < 8) r[13:8] = 6'h3f;
			extended_set_enable = k != 5;
			instr_valid = k != 7;
			// The disabled kind also offers the return and call forms
			instr_word = {k == 6 ? 8'he9 : 8'he8, k == 5 ? r[15:14] : k[1:0], r[13:8]};
			if (k == 4 || (k == 5 && r[16])) instr_word = 16'h0014;
			{pc_upper_latch, pc_high_latch, working_reg, pc_current, return_stack_top} = {q[30:0], r};
			s = k == 3 ? 2 : k;
			@(negedge clk_sys);
			`CHK({instr_taken, ptr_we, nop_cycle}, {k < 5, k < 4, 1'b0})
			`CHK({pc_load, stack_push}, {k == 3 || k == 4, k == 4})
			`CHK(status_write_en, 1'b0)
			`CHK(shadow_save_en, 1'b0)
			if (k < 4) begin
				m[s] = sum(m[s], r[13:8]);
				`CHK({ptr_sel, ptr_wdata}, {s[1:0], m[s]})
			end
			if (k == 3) `CHK(pc_next, return_stack_top)
			if (k == 4) `CHK({pc_next, stack_push_data}, {q[30:10], pc_current + 21'h2})
			if (k == 3 || k == 4) begin
				// An add arriving in the flush cycle must be dropped
				instr_word = {8'he8, r[7:0]};
				@(negedge clk_sys);
				`CHK({nop_cycle, ptr_we, pc_load, stack_push, instr_taken}, 5'h10)
			end
			`CHK({pointer_reg_2, pointer_reg_1, pointer_reg_0}, {m[2], m[1], m[0]})
		end
		final_report;
	end
endmodule
`default_nettype wire
